// file: hw/adc_cfg_pkg.sv
// constants for the converter configuration and result-format block
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
package adc_cfg_pkg;

   // register byte addresses
   localparam logic [7:0] OFS_CONVERTER_CONTROL_ZERO = 8'h00;
   localparam logic [7:0] OFS_CONVERTER_CONTROL_ONE = 8'h04;
   localparam logic [7:0] OFS_RESULT_HIGH_BYTE = 8'h08;
   localparam logic [7:0] OFS_RESULT_LOW_BYTE = 8'h0C;
   localparam logic [7:0] OFS_CONVERTER_STATUS = 8'h10;

   // converter_control_zero fields
   localparam int BIT_CONVERTER_ON = 0;

   // converter_control_one fields
   localparam int BIT_RESULT_JUSTIFY = 7;
   localparam int LSB_CONV_CLOCK_SELECT = 4;
   localparam int BIT_NEG_REF_SELECT = 2;
   localparam int LSB_POS_REF_SELECT = 0;
   localparam logic [7:0] CTRL1_WRITE_MASK = 8'hF7;
   localparam logic [7:0] CTRL1_RESET = 8'h00;

   // converter_status fields
   localparam int BIT_STAT_ACTIVE = 0;
   localparam int BIT_STAT_ABORTED = 1;
   localparam int BIT_STAT_RC_CLOCK = 2;

   // conversion clock select codes
   localparam logic [2:0] CCS_DIV2 = 3'h0;
   localparam logic [2:0] CCS_DIV8 = 3'h1;
   localparam logic [2:0] CCS_DIV32 = 3'h2;
   localparam logic [2:0] CCS_RC_A = 3'h3;
   localparam logic [2:0] CCS_DIV4 = 3'h4;
   localparam logic [2:0] CCS_DIV16 = 3'h5;
   localparam logic [2:0] CCS_DIV64 = 3'h6;
   localparam logic [2:0] CCS_RC_B = 3'h7;

   // positive reference codes
   localparam logic [1:0] PREF_SUPPLY = 2'h0;
   localparam logic [1:0] PREF_RESERVED = 2'h1;
   localparam logic [1:0] PREF_EXTERNAL = 2'h2;
   localparam logic [1:0] PREF_FIXED = 2'h3;

   // result width and justification padding
   localparam int RESULT_WIDTH = 10;
   localparam int PAD_BITS = 6;

   // reset values
   localparam logic [7:0] DIV_COUNT_RESET = 8'h00;

endpackage

// file: hw/result_formatter.sv
// result formatter: packs a 10-bit conversion result into high and low bytes
// assumes the caller registers the outputs on its own load strobe
`timescale 1ns/10ps
module result_formatter (
   input wire logic result_justify,
   input wire logic [9:0] conversion_result,
   output logic [7:0] high_byte,
   output logic [7:0] low_byte
);

   always_comb begin
      if (result_justify) begin
         high_byte = {6'h00, conversion_result[9:8]};
         low_byte = conversion_result[7:0];
      end else begin
         high_byte = conversion_result[9:2];
         low_byte = {conversion_result[1:0], 6'h00};
      end
   end

endmodule

// file: hw/conv_clock_divider.sv
// conversion clock generator: one-cycle ticks from a divided system clock or the rc oscillator
// assumes rc_osc_tick is a one-cycle pulse synchronous to mclk
`timescale 1ns/10ps
module conv_clock_divider #(
   parameter int CNT_W = 8
) (
   input wire logic mclk,
   input wire logic rst_sync_n,
   input wire logic run,
   input wire logic [2:0] conv_clock_select,
   input wire logic rc_osc_tick,
   output logic conv_tick
);

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic tick_r;
   logic tick_nxt;

   // terminal count for each divide code; rc codes return zero
   function automatic logic [CNT_W-1:0] last_count(input logic [2:0] sel);
      case (sel)
         adc_cfg_pkg::CCS_DIV2: last_count = CNT_W'(1);
         adc_cfg_pkg::CCS_DIV4: last_count = CNT_W'(3);
         adc_cfg_pkg::CCS_DIV8: last_count = CNT_W'(7);
         adc_cfg_pkg::CCS_DIV16: last_count = CNT_W'(15);
         adc_cfg_pkg::CCS_DIV32: last_count = CNT_W'(31);
         adc_cfg_pkg::CCS_DIV64: last_count = CNT_W'(63);
         default: last_count = '0;
      endcase
   endfunction

   always_comb begin
      count_nxt = count_r;
      tick_nxt = 1'b0;
      if (!run) begin
         count_nxt = '0;
      end else if (conv_clock_select == adc_cfg_pkg::CCS_RC_A ||
                   conv_clock_select == adc_cfg_pkg::CCS_RC_B) begin
         count_nxt = '0;
         tick_nxt = rc_osc_tick;
      end else if (count_r >= last_count(conv_clock_select)) begin
         count_nxt = '0;
         tick_nxt = 1'b1;
      end else begin
         count_nxt = count_r + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count_r <= adc_cfg_pkg::DIV_COUNT_RESET[CNT_W-1:0];
         tick_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign conv_tick = tick_r;

endmodule

// file: hw/adc_config_and_result_format.sv
// converter configuration and result format block with a wishbone register slave
// assumes the converter core gives a one-cycle load strobe with a 10-bit result,
// and that sleep_req is a level held by the power controller while asleep
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module adc_config_and_result_format (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic result_load,
   input wire logic [9:0] conversion_result,
   input wire logic sleep_req,
   input wire logic rc_osc_tick,
   output logic conv_clk_tick,
   output logic converter_active,
   output logic conv_abort,
   output logic mux_connect,
   output logic neg_ref_gnd,
   output logic neg_ref_ext,
   output logic pos_ref_supply,
   output logic pos_ref_ext,
   output logic pos_ref_fixed
);

   // reset release synchroniser
   logic rst_meta_r;
   logic rst_sync_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // register state
   logic converter_on_r;
   logic converter_on_nxt;
   logic [7:0] ctrl1_r;
   logic [7:0] ctrl1_nxt;
   logic aborted_r;
   logic aborted_nxt;
   logic active_r;
   logic active_nxt;
   logic abort_r;
   logic abort_nxt;
   logic sleep_d_r;
   logic ack_r;
   logic ack_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic mux_r;
   logic mux_nxt;
   logic [4:0] refs_r;
   logic [4:0] refs_nxt;

   // result bytes keep no reset so other resets leave them untouched
   logic [7:0] result_high_r;
   logic [7:0] result_high_nxt;
   logic [7:0] result_low_r;
   logic [7:0] result_low_nxt;

   logic result_justify;
   logic [2:0] conv_clock_select;
   logic neg_ref_select;
   logic [1:0] pos_ref_select;
   logic rc_clocked;
   logic sleep_entry;
   logic bus_req;
   logic wr_commit;
   logic [7:0] fmt_high;
   logic [7:0] fmt_low;

   assign result_justify = ctrl1_r[adc_cfg_pkg::BIT_RESULT_JUSTIFY];
   assign conv_clock_select = ctrl1_r[adc_cfg_pkg::LSB_CONV_CLOCK_SELECT +: 3];
   assign neg_ref_select = ctrl1_r[adc_cfg_pkg::BIT_NEG_REF_SELECT];
   assign pos_ref_select = ctrl1_r[adc_cfg_pkg::LSB_POS_REF_SELECT +: 2];
   assign rc_clocked = (conv_clock_select == adc_cfg_pkg::CCS_RC_A) ||
                       (conv_clock_select == adc_cfg_pkg::CCS_RC_B);
   assign sleep_entry = sleep_req && !sleep_d_r;
   assign bus_req = wb_cyc_i && wb_stb_i;
   // writes take effect at the edge where the master sees ack
   assign wr_commit = bus_req && wb_we_i && ack_r && wb_sel_i[0];

   result_formatter u_fmt (
      .result_justify(result_justify),
      .conversion_result(conversion_result),
      .high_byte(fmt_high),
      .low_byte(fmt_low)
   );

   conv_clock_divider #(
      .CNT_W(8)
   ) u_div (
      .mclk(mclk),
      .rst_sync_n(rst_sync_r),
      .run(active_r),
      .conv_clock_select(conv_clock_select),
      .rc_osc_tick(rc_osc_tick),
      .conv_tick(conv_clk_tick)
   );

   // bus slave: one-cycle ack, read data captured with it
   always_comb begin
      ack_nxt = bus_req && !ack_r;
      rdata_nxt = rdata_r;
      if (bus_req && !ack_r) begin
         rdata_nxt = 32'h0000_0000;
         if (!wb_we_i) begin
            case (wb_adr_i)
               adc_cfg_pkg::OFS_CONVERTER_CONTROL_ZERO:
                  rdata_nxt[adc_cfg_pkg::BIT_CONVERTER_ON] = converter_on_r;
               adc_cfg_pkg::OFS_CONVERTER_CONTROL_ONE:
                  rdata_nxt[7:0] = ctrl1_r;
               adc_cfg_pkg::OFS_RESULT_HIGH_BYTE:
                  rdata_nxt[7:0] = result_high_r;
               adc_cfg_pkg::OFS_RESULT_LOW_BYTE:
                  rdata_nxt[7:0] = result_low_r;
               adc_cfg_pkg::OFS_CONVERTER_STATUS: begin
                  rdata_nxt[adc_cfg_pkg::BIT_STAT_ACTIVE] = active_r;
                  rdata_nxt[adc_cfg_pkg::BIT_STAT_ABORTED] = aborted_r;
                  rdata_nxt[adc_cfg_pkg::BIT_STAT_RC_CLOCK] = rc_clocked;
               end
               default: rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   // control registers and sleep handling
   always_comb begin
      converter_on_nxt = converter_on_r;
      ctrl1_nxt = ctrl1_r;
      aborted_nxt = aborted_r;
      if (wr_commit) begin
         case (wb_adr_i)
            adc_cfg_pkg::OFS_CONVERTER_CONTROL_ZERO:
               converter_on_nxt = wb_dat_i[adc_cfg_pkg::BIT_CONVERTER_ON];
            adc_cfg_pkg::OFS_CONVERTER_CONTROL_ONE:
               ctrl1_nxt = wb_dat_i[7:0] & adc_cfg_pkg::CTRL1_WRITE_MASK;
            adc_cfg_pkg::OFS_CONVERTER_STATUS:
               if (wb_dat_i[adc_cfg_pkg::BIT_STAT_ABORTED]) begin
                  aborted_nxt = 1'b0;
               end
            default: ;
         endcase
      end
      // abort is noted even if software clears the flag in the same cycle
      abort_nxt = sleep_entry && converter_on_r && !rc_clocked;
      if (abort_nxt) begin
         aborted_nxt = 1'b1;
      end
      // enable bit stays set; only the running state drops in sleep, and only when the rc clock is not selected
      active_nxt = converter_on_r && !(sleep_req && !rc_clocked);
   end

   // reference and channel multiplexer selection
   always_comb begin
      mux_nxt = converter_on_r;
      refs_nxt = 5'h00;
      if (converter_on_r) begin
         refs_nxt[0] = !neg_ref_select;
         refs_nxt[1] = neg_ref_select;
         // reserved positive code connects nothing
         case (pos_ref_select)
            adc_cfg_pkg::PREF_SUPPLY: refs_nxt[2] = 1'b1;
            adc_cfg_pkg::PREF_EXTERNAL: refs_nxt[3] = 1'b1;
            adc_cfg_pkg::PREF_FIXED: refs_nxt[4] = 1'b1;
            default: refs_nxt[4:2] = 3'h0;
         endcase
      end
   end

   // result bytes: a load from the core wins over a software write
   always_comb begin
      result_high_nxt = result_high_r;
      result_low_nxt = result_low_r;
      if (result_load) begin
         result_high_nxt = fmt_high;
         result_low_nxt = fmt_low;
      end else if (wr_commit) begin
         if (wb_adr_i == adc_cfg_pkg::OFS_RESULT_HIGH_BYTE) begin
            result_high_nxt = wb_dat_i[7:0];
         end
         if (wb_adr_i == adc_cfg_pkg::OFS_RESULT_LOW_BYTE) begin
            result_low_nxt = wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      result_high_r <= result_high_nxt;
      result_low_r <= result_low_nxt;
   end

   always_ff @(posedge mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         converter_on_r <= 1'b0;
         ctrl1_r <= adc_cfg_pkg::CTRL1_RESET;
         aborted_r <= 1'b0;
         active_r <= 1'b0;
         abort_r <= 1'b0;
         sleep_d_r <= 1'b0;
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         mux_r <= 1'b0;
         refs_r <= 5'h00;
      end else begin
         converter_on_r <= converter_on_nxt;
         ctrl1_r <= ctrl1_nxt;
         aborted_r <= aborted_nxt;
         active_r <= active_nxt;
         abort_r <= abort_nxt;
         sleep_d_r <= sleep_req;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
         mux_r <= mux_nxt;
         refs_r <= refs_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;
   assign converter_active = active_r;
   assign conv_abort = abort_r;
   assign mux_connect = mux_r;
   assign neg_ref_gnd = refs_r[0];
   assign neg_ref_ext = refs_r[1];
   assign pos_ref_supply = refs_r[2];
   assign pos_ref_ext = refs_r[3];
   assign pos_ref_fixed = refs_r[4];

endmodule

// file: dv/adc_cfg_asserts.sv
// checker for the converter configuration and result format block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module adc_cfg_asserts (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sleep_req,
   input wire logic converter_active,
   input wire logic conv_abort,
   input wire logic mux_connect,
   input wire logic neg_ref_gnd,
   input wire logic neg_ref_ext,
   input wire logic pos_ref_supply,
   input wire logic pos_ref_ext,
   input wire logic pos_ref_fixed
);
   logic rc_r;
   logic rc_nxt;
   // tracks whether software chose the rc oscillator as conversion clock
   always_comb begin
      rc_nxt = rc_r;
      if (wb_ack_o && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == adc_cfg_pkg::OFS_CONVERTER_CONTROL_ONE) begin
         rc_nxt = wb_dat_i[5:4] == 2'b11;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rc_r <= 1'b0;
      else rc_r <= rc_nxt;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   mux_off_a: assert property (!mux_connect |->
      !(neg_ref_gnd || neg_ref_ext || pos_ref_supply || pos_ref_ext || pos_ref_fixed))
      else $error("switch closed while disabled");
   neg_ref_a: assert property (mux_connect |-> neg_ref_gnd != neg_ref_ext)
      else $error("negative reference not one of two");
   pos_ref_a: assert property ($onehot0({pos_ref_supply, pos_ref_ext, pos_ref_fixed}))
      else $error("two positive references");
   sleep_abort_a: assert property ($rose(sleep_req) && mux_connect && !rc_r |=>
      conv_abort && !converter_active) else $error("no abort on sleep");
   abort_pulse_a: assert property (conv_abort |=> !conv_abort)
      else $error("abort longer than one cycle");
   sleep_off_a: assert property (sleep_req && !rc_r ##1 sleep_req |-> !converter_active)
      else $error("converter on in sleep");
   rc_sleep_a: assert property (sleep_req && rc_r |-> !conv_abort)
      else $error("abort with rc clock");
   cover property ($rose(conv_abort));
   cover property (sleep_req && rc_r && converter_active);
   cover property (wb_ack_o && !wb_we_i);
endmodule
bind adc_config_and_result_format adc_cfg_asserts u_chk (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_req, .converter_active,
   .conv_abort, .mux_connect, .neg_ref_gnd, .neg_ref_ext, .pos_ref_supply, .pos_ref_ext,
   .pos_ref_fixed);

// file: dv/adc_config_and_result_format_test.sv
// testbench for the converter configuration and result format block
// assumes a one-byte-per-word wishbone slave and a free-running rc tick
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module adc_config_and_result_format_test;
   localparam logic [7:0] C0 = adc_cfg_pkg::OFS_CONVERTER_CONTROL_ZERO;
   localparam logic [7:0] C1 = adc_cfg_pkg::OFS_CONVERTER_CONTROL_ONE;
   localparam logic [7:0] HI = adc_cfg_pkg::OFS_RESULT_HIGH_BYTE;
   localparam logic [7:0] LO = adc_cfg_pkg::OFS_RESULT_LOW_BYTE;
   localparam logic [7:0] ST = adc_cfg_pkg::OFS_CONVERTER_STATUS;
   localparam int DIVS[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   logic mclk = 0;
   logic rst_n = 0;
   logic wb_cyc_i = 0;
   logic wb_stb_i = 0;
   logic wb_we_i = 0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic result_load = 0;
   logic [9:0] conversion_result = 10'h000;
   logic sleep_req = 0;
   logic rc_osc_tick = 0;
   logic conv_clk_tick, converter_active, conv_abort, mux_connect;
   logic neg_ref_gnd, neg_ref_ext, pos_ref_supply, pos_ref_ext, pos_ref_fixed;
   logic [7:0] rd;
   int errors = 0;
   int n_compared = 0;
   int n_tick = 0;
   int n_abort = 0;
   int rc_cnt = 0;
   int t0, a0;
   adc_config_and_result_format u_dut (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .result_load, .conversion_result,
      .sleep_req, .rc_osc_tick, .conv_clk_tick, .converter_active, .conv_abort, .mux_connect,
      .neg_ref_gnd, .neg_ref_ext, .pos_ref_supply, .pos_ref_ext, .pos_ref_fixed);
   always #2.5 mclk = ~mclk;
   // rc oscillator stand-in: one tick every 20 system cycles
   always @(posedge mclk) begin
      rc_cnt <= (rc_cnt == 19) ? 0 : rc_cnt + 1;
      rc_osc_tick <= (rc_cnt == 19);
      if (conv_clk_tick === 1'b1) n_tick++;
      if (conv_abort === 1'b1) n_abort++;
   end
   task automatic end_of_test;
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      wb_sel_i <= 4'h1;
      do begin
         @(posedge mclk);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 50);
      `CHK(wb_ack_o, 1'b1)
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      `CHK(rd, e)
   endtask
   task automatic load(input logic [9:0] v);
      @(posedge mclk);
      result_load <= 1'b1;
      conversion_result <= v;
      @(posedge mclk);
      result_load <= 1'b0;
      conversion_result <= ~v;
   endtask
   task automatic do_reset;
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
   task automatic count(input int n);
      @(negedge mclk);
      t0 = n_tick;
      repeat (n) @(negedge mclk);
      @(posedge mclk);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rdchk(C1, 8'h00);
      xfer(1'b1, C1, 8'hFF);
      rdchk(C1, 8'hF7);
      xfer(1'b1, 8'h20, 8'h5A);
      rdchk(8'h20, 8'h00);
      xfer(1'b1, C1, 8'h80);
      load(10'h3A5);
      rdchk(HI, 8'h03);
      rdchk(LO, 8'hA5);
      xfer(1'b1, C1, 8'h00);
      load(10'h3A5);
      rdchk(HI, 8'hE9);
      rdchk(LO, 8'h40);
      xfer(1'b1, HI, 8'hC3);
      xfer(1'b1, LO, 8'h3C);
      do_reset();
      rdchk(HI, 8'hC3);
      rdchk(LO, 8'h3C);
      xfer(1'b1, C0, 8'h01);
      for (int k = 0; k < 8; k++) begin
         // software never programs the reserved positive reference code
         if (k[1:0] == 2'd1) continue;
         xfer(1'b1, C1, k[7:0]);
         repeat (3) @(posedge mclk);
         `CHK({neg_ref_ext, neg_ref_gnd}, {k[2], !k[2]})
         `CHK({pos_ref_fixed, pos_ref_ext, pos_ref_supply}, {k[1:0] == 2'd3, k[1:0] == 2'd2,
            k[1:0] == 2'd0})
      end
      xfer(1'b1, C0, 8'h00);
      repeat (3) @(posedge mclk);
      `CHK({mux_connect, neg_ref_ext, pos_ref_fixed}, 3'b000)
      xfer(1'b1, C0, 8'h01);
      for (int k = 0; k < 8; k++) begin
         xfer(1'b1, C1, {1'b0, k[2:0], 4'h0});
         repeat (130) @(posedge mclk);
         count(640);
         `CHK(n_tick - t0, DIVS[k] == 0 ? 32 : 640 / DIVS[k])
      end
      xfer(1'b1, C1, 8'h00);
      repeat (10) @(posedge mclk);
      a0 = n_abort;
      sleep_req <= 1'b1;
      repeat (4) @(posedge mclk);
      count(64);
      `CHK(n_tick - t0, 0)
      `CHK(n_abort - a0, 1)
      `CHK(converter_active, 1'b0)
      rdchk(C0, 8'h01);
      rdchk(ST, 8'h02);
      sleep_req <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK(converter_active, 1'b1)
      xfer(1'b1, C1, 8'h30);
      repeat (130) @(posedge mclk);
      a0 = n_abort;
      sleep_req <= 1'b1;
      count(640);
      `CHK(n_tick - t0, 32)
      `CHK(n_abort - a0, 0)
      `CHK(converter_active, 1'b1)
      rdchk(ST, 8'h07);
      xfer(1'b1, ST, 8'h02);
      rdchk(ST, 8'h05);
      sleep_req <= 1'b0;
      end_of_test();
   end
   initial begin
      repeat (30000) @(posedge mclk);
      errors++;
      end_of_test();
   end
endmodule
